// [pkg/vpa_pkg.sv]
// Constants, state codes and timing counts for the Port A access sequencer.
package vpa_pkg;
  localparam int   CLK_PERIOD_NS   = 100;
  // Minimum times in nanoseconds, converted to whole clock cycles rounded up.
  localparam int   ROW_HOLD_NS     = 100;
  localparam int   COL_SETUP_NS    = 100;
  localparam int   COL_HOLD_NS     = 100;
  localparam int   PRECHARGE_NS    = 200;
  localparam int   ROW_HOLD_CYC    = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int   COL_SETUP_CYC   = (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int   COL_HOLD_CYC    = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int   PRECHARGE_CYC   = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int   ADDR_W          = 9;
  localparam int   BANK_W          = 2;
  localparam int   STROBE_W        = 4;
  localparam int   CNT_W           = 3;
  localparam logic CFG_RESET       = 1'h0;

  typedef enum logic [2:0] {
    VPA_IDLE  = 3'h0,
    VPA_ROW   = 3'h1,
    VPA_CSET  = 3'h2,
    VPA_WDLY  = 3'h3,
    VPA_COL   = 3'h4,
    VPA_PRE   = 3'h5
  } vpa_state_t;
endpackage

// [rtl/vpa_sequencer.sv]
// Port A access sequencer: request latch, row/column strobe timing and address multiplexer.
`timescale 1ns/10ps
`default_nettype none

module vpa_sequencer
  import vpa_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                program_i,
  input  wire logic                mode_select_bit_i,
  input  wire logic                write_column_delay_bit_i,
  input  wire logic                early_column_cfg_bit_i,
  input  wire logic                ack_style_bit_i,
  input  wire logic                pipeline_cfg_i,
  input  wire logic                addr_latch_cfg_i,
  input  wire logic                address_strobe_in_i,
  input  wire logic                chip_select_i,
  input  wire logic                access_hold_request_i,
  input  wire logic                write_indicator_in_i,
  input  wire logic [STROBE_W-1:0] byte_column_enables_i,
  input  wire logic [BANK_W-1:0]   bank_i,
  input  wire logic [ADDR_W-1:0]   row_addr_i,
  input  wire logic [ADDR_W-1:0]   col_addr_i,
  input  wire logic                refresh_busy_i,
  input  wire logic                port_b_busy_i,
  input  wire logic                transfer_busy_i,
  output logic [STROBE_W-1:0]      row_strobe_o,
  output logic [STROBE_W-1:0]      column_strobe_o,
  output logic [ADDR_W-1:0]        mux_address_out_o,
  output logic                     transfer_output_enable_o,
  output logic                     transfer_ack_out_o
);

  vpa_state_t        state;
  vpa_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic              cfg_mode;
  logic              cfg_wdly;
  logic              cfg_ecol;
  logic              cfg_ack;
  logic              cfg_pipe;
  logic              cfg_latch;
  logic              strobe_prev;
  logic              req;
  logic              hold_seen;
  logic [ADDR_W-1:0] pend_row;
  logic [ADDR_W-1:0] pend_col;
  logic [BANK_W-1:0] pend_bank;
  logic              pend_write;
  logic [ADDR_W-1:0] cur_row;
  logic [ADDR_W-1:0] cur_col;
  logic [BANK_W-1:0] cur_bank;
  logic              cur_write;
  logic              start_now;
  logic              busy;
  logic              accept;
  logic              can_start;
  logic              active;
  logic              ending;
  logic [ADDR_W-1:0] take_row;
  logic [ADDR_W-1:0] take_col;
  logic [BANK_W-1:0] take_bank;
  logic              take_write;
  logic [STROBE_W-1:0] next_row_strobe;
  logic [STROBE_W-1:0] next_col_strobe;
  logic [ADDR_W-1:0]   next_mux;
  logic                next_ack;

  // A start needs a fresh rising strobe, so a strobe held high cannot start twice.
  assign start_now  = address_strobe_in_i & chip_select_i & ~strobe_prev;
  assign busy       = refresh_busy_i | port_b_busy_i | transfer_busy_i;
  assign active     = (state == VPA_ROW) || (state == VPA_CSET) || (state == VPA_WDLY) || (state == VPA_COL);
  assign ending     = active & hold_seen & ~access_hold_request_i;
  // Mode 1 starts at the strobe edge; a request queued mid-access waits until the sequencer is free.
  assign can_start  = (state == VPA_IDLE) || ((state == VPA_PRE) && (cnt >= CNT_W'(PRECHARGE_CYC - 1)));
  assign accept     = ~busy & can_start & (req | (cfg_mode & start_now & ~active));
  assign take_row   = req ? pend_row : row_addr_i;
  assign take_col   = req ? pend_col : col_addr_i;
  assign take_bank  = req ? pend_bank : bank_i;
  assign take_write = req ? pend_write : write_indicator_in_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {cfg_mode, cfg_wdly, cfg_ecol, cfg_ack, cfg_pipe, cfg_latch} <= {6{CFG_RESET}};
    end else if (ce_i && program_i) begin
      cfg_mode  <= mode_select_bit_i;
      cfg_wdly  <= write_column_delay_bit_i;
      cfg_ecol  <= early_column_cfg_bit_i;
      cfg_ack   <= ack_style_bit_i;
      cfg_pipe  <= pipeline_cfg_i;
      cfg_latch <= addr_latch_cfg_i;
    end
  end

  // Request latch and pending address; a held-off request waits here.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_prev <= 1'h0;
      req         <= 1'h0;
      {pend_row, pend_col, pend_bank, pend_write} <= '0;
    end else if (ce_i) begin
      strobe_prev <= address_strobe_in_i;
      if (accept && !req) begin
        req <= 1'h0;
      end else begin
        req <= (req & ~accept) | start_now;
      end
      if (start_now || (cfg_latch && strobe_prev && !address_strobe_in_i && req)) begin
        pend_row   <= row_addr_i;
        pend_col   <= col_addr_i;
        pend_bank  <= bank_i;
        pend_write <= write_indicator_in_i;
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      VPA_IDLE: begin
        if (accept) begin
          next_state = VPA_ROW;
        end
      end
      VPA_ROW: begin
        if (ending) begin
          next_state = VPA_PRE;
        end else if (cnt >= CNT_W'(ROW_HOLD_CYC - 1)) begin
          next_state = VPA_CSET;
        end
      end
      VPA_CSET: begin
        if (ending) begin
          next_state = VPA_PRE;
        end else if (cnt >= CNT_W'(COL_SETUP_CYC - 1)) begin
          next_state = (cfg_wdly && cur_write) ? VPA_WDLY : VPA_COL;
        end
      end
      VPA_WDLY: begin
        next_state = ending ? VPA_PRE : VPA_COL;
      end
      VPA_COL: begin
        if (ending) begin
          next_state = VPA_PRE;
        end
      end
      VPA_PRE: begin
        if (cnt >= CNT_W'(PRECHARGE_CYC - 1)) begin
          next_state = accept ? VPA_ROW : VPA_IDLE;
        end
      end
      default: begin
        next_state = VPA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= VPA_IDLE;
      cnt       <= '0;
      hold_seen <= 1'h0;
    end else if (ce_i) begin
      state     <= next_state;
      cnt       <= (next_state != state) ? '0 : ((cnt == '1) ? cnt : cnt + CNT_W'(1));
      hold_seen <= (next_state == VPA_ROW && state != VPA_ROW) ? access_hold_request_i
                                                                : (hold_seen | access_hold_request_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {cur_row, cur_col, cur_bank, cur_write} <= '0;
    end else if (ce_i && next_state == VPA_ROW && state != VPA_ROW) begin
      cur_row   <= take_row;
      cur_col   <= take_col;
      cur_bank  <= take_bank;
      cur_write <= take_write;
    end
  end

  always_comb begin
    next_row_strobe = '0;
    next_col_strobe = '0;
    next_mux        = mux_address_out_o;
    unique case (next_state)
      VPA_ROW: begin
        next_row_strobe = (state == VPA_ROW) ? row_strobe_o : STROBE_W'(1) << take_bank;
        next_mux        = (state == VPA_ROW) ? cur_row : take_row;
      end
      VPA_CSET, VPA_WDLY: begin
        next_row_strobe = row_strobe_o;
        next_mux        = cur_col;
      end
      VPA_COL: begin
        next_row_strobe = row_strobe_o;
        next_col_strobe = byte_column_enables_i;
        // Pipelining frees the address bus early for the next row address: the queued one if a request waits, else the live one.
        if (cfg_pipe && state == VPA_COL && cnt >= CNT_W'(COL_HOLD_CYC - 1)) begin
          next_mux = req ? pend_row : row_addr_i;
        end else if (!cfg_pipe || state != VPA_COL) begin
          next_mux = cur_col;
        end
      end
      VPA_PRE: begin
        next_col_strobe = cfg_ecol ? '0 : column_strobe_o;
      end
      default: begin
        next_mux = mux_address_out_o;
      end
    endcase
    if (cfg_ack) begin
      next_ack = (next_state == VPA_COL);
    end else begin
      next_ack = ~((next_state == VPA_ROW) || (next_state == VPA_CSET) || (next_state == VPA_WDLY));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_strobe_o             <= '0;
      column_strobe_o          <= '0;
      mux_address_out_o        <= '0;
      transfer_output_enable_o <= 1'h0;
      transfer_ack_out_o       <= 1'h1;
    end else if (ce_i) begin
      row_strobe_o             <= next_row_strobe;
      column_strobe_o          <= next_col_strobe;
      mux_address_out_o        <= next_mux;
      transfer_output_enable_o <= ~cur_write & ~cfg_ecol & (|next_col_strobe);
      transfer_ack_out_o       <= next_ack;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_mode0_row_start: assert property (state == VPA_IDLE && req && !busy |=> row_strobe_o != '0)
    else $error("Latched request did not raise row strobes at the next edge.");
  a_mode1_direct: assert property (cfg_mode && state == VPA_IDLE && start_now && !busy |=> row_strobe_o != '0)
    else $error("Mode 1 strobe did not raise row strobes directly.");
  a_busy_holds_off: assert property (state == VPA_IDLE && busy |=> row_strobe_o == '0)
    else $error("Row strobes rose while arbitration was busy.");
  a_pending_kept: assert property (req && busy |=> req)
    else $error("Held-off request was dropped.");
  a_queue_kept: assert property (req && active |=> req)
    else $error("Request queued during an access was dropped.");
  a_hold_end_row: assert property (ending |=> row_strobe_o == '0 ##1 row_strobe_o == '0)
    else $error("Row strobes stayed up after hold release.");
  a_early_col_drop: assert property (ending && cfg_ecol |=> column_strobe_o == '0)
    else $error("Column strobes did not drop with hold release.");
  a_col_keep: assert property (state == VPA_COL && ending && !cfg_ecol |=> column_strobe_o == $past(column_strobe_o))
    else $error("Column strobes did not stay after row strobes fell.");
  a_col_setup: assert property ($rose(|column_strobe_o) |-> $past(mux_address_out_o) == cur_col)
    else $error("Column address was not set up before column strobes.");
  a_write_delay: assert property (state == VPA_WDLY |-> column_strobe_o == '0 && cfg_wdly && cur_write)
    else $error("Write column delay cycle misbehaved.");
  a_read_oe: assert property (!cur_write && !cfg_ecol && state != VPA_ROW |-> transfer_output_enable_o == (|column_strobe_o))
    else $error("Output enable did not follow column strobes on a read.");
  a_transfer_ack_out_style: assert property (cfg_ack && state == VPA_COL |-> transfer_ack_out_o)
    else $error("Acknowledge missing during column phase.");

  c_full_access: cover property (state == VPA_COL ##[1:20] state == VPA_PRE);
  c_write_delay: cover property (state == VPA_WDLY);
  c_pipelined:   cover property (cfg_pipe && state == VPA_COL && req);
  c_blocked:     cover property (req && busy ##1 !busy);

endmodule

`default_nettype wire

// [testbench/vpa_host_model.sv]
// Port A host model that starts, holds and ends single accesses.
`timescale 1ns/10ps
`default_nettype none
module vpa_host_model
  import vpa_pkg::*;
(
  input  wire logic [STROBE_W-1:0] row_strobe_i,
  input  wire logic                clk_i,
  output logic                     strobe_o,
  output logic                     select_o,
  output logic                     hold_o,
  output logic                     write_o,
  output logic [STROBE_W-1:0]      enables_o,
  output logic [BANK_W-1:0]        bank_o,
  output logic [ADDR_W-1:0]        row_o,
  output logic [ADDR_W-1:0]        col_o
);
  initial begin
    {strobe_o, select_o, hold_o, write_o} = 4'h0;
    {enables_o, bank_o, row_o, col_o} = '0;
  end

  // Every change follows a rising edge by 1 ns.
  task automatic access(input logic wr, input logic [3:0] en, input logic [1:0] bk,
                        input logic [8:0] ra, input logic [8:0] ca, input int hold_cyc, input logic keep);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    {strobe_o, select_o, write_o, enables_o, bank_o, row_o, col_o} = {2'h3, wr, en, bk, ra, ca};
    while (row_strobe_i === 4'h0 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    hold_o = 1'h1;
    @(posedge clk_i);
    #1;
    select_o = keep;
    strobe_o = keep;
    // The address was taken at the start, so the released lines toggle.
    {row_o, col_o, bank_o} = ~{ra, ca, bk};
    repeat (hold_cyc) @(posedge clk_i);
    #1;
    hold_o = 1'h0;
    repeat (6) @(posedge clk_i);
    #1;
    strobe_o = 1'h0;
    select_o = 1'h0;
    // The write enable to the memory is the host's own business.
  endtask
endmodule
`default_nettype wire

// [testbench/vpa_sequencer_tb.sv]
// Self-checking bench for the Port A access sequencer.
`timescale 1ns/10ps
`default_nettype none
module vpa_sequencer_tb
  import vpa_pkg::*;
;
  logic                clk_i = 1'h0;
  logic                rst_i = 1'h1;
  logic                prog = 1'h0, mode = 1'h0, wdly = 1'h0, ecol = 1'h0, style = 1'h0;
  logic                pipe = 1'h0, latch_cfg = 1'h0;
  logic [2:0]          busy = 3'h0;
  logic                stb, cs, hold, wr, oe, ack;
  logic [STROBE_W-1:0] en, row_s, col_s;
  logic [BANK_W-1:0]   bank;
  logic [ADDR_W-1:0]   ra, ca, mux;
  logic [31:0]         lfsr = 32'h5C98;
  logic [31:0]         exp_q[$];
  int                  fails = 0, n_checks = 0, cyc = 0, t_stb = 0, t_row = 0, t_hold = 0;
  logic                p_stb = 1'h0, p_hold = 1'h0;
  logic [STROBE_W-1:0] p_row = 4'h0, p_col = 4'h0;

  always #50 clk_i = ~clk_i;

  vpa_sequencer vpa_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .program_i(prog), .mode_select_bit_i(mode),
    .write_column_delay_bit_i(wdly), .early_column_cfg_bit_i(ecol), .ack_style_bit_i(style),
    .pipeline_cfg_i(pipe), .addr_latch_cfg_i(latch_cfg), .address_strobe_in_i(stb), .chip_select_i(cs),
    .access_hold_request_i(hold), .write_indicator_in_i(wr), .byte_column_enables_i(en), .bank_i(bank),
    .row_addr_i(ra), .col_addr_i(ca), .refresh_busy_i(busy[0]), .port_b_busy_i(busy[1]),
    .transfer_busy_i(busy[2]), .row_strobe_o(row_s), .column_strobe_o(col_s), .mux_address_out_o(mux),
    .transfer_output_enable_o(oe), .transfer_ack_out_o(ack));

  vpa_host_model vpa_host_model_inst (
    .row_strobe_i(row_s), .clk_i(clk_i), .strobe_o(stb), .select_o(cs), .hold_o(hold), .write_o(wr),
    .enables_o(en), .bank_o(bank), .row_o(ra), .col_o(ca));

  function automatic logic [31:0] next_rand();
    for (int k = 0; k < 8; k++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
    return lfsr;
  endfunction

  task automatic check_note(input logic [31:0] got);
    logic [31:0] exp;
    exp = (exp_q.size() != 0) ? exp_q.pop_front() : 32'h0;
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Result word: kind, cycle distance, strobes, address, output enable, acknowledge.
  always @(negedge clk_i) begin
    cyc++;
    if ((stb & cs) === 1'h1 && p_stb === 1'h0) t_stb = cyc;
    if (hold === 1'h0 && p_hold === 1'h1) t_hold = cyc;
    if (row_s !== 4'h0 && p_row === 4'h0) begin
      t_row = cyc;
      check_note({2'h1, 4'(cyc - t_stb), row_s, mux, oe, ack, 11'h0});
    end
    if (col_s !== 4'h0 && p_col === 4'h0)
      check_note({2'h2, 4'(cyc - t_row), col_s, mux, oe, ack, 11'h0});
    if (row_s === 4'h0 && p_row !== 4'h0)
      check_note({2'h3, 4'(cyc - t_hold), col_s, mux, oe, ack, 11'h0});
    p_stb = stb & cs;
    p_hold = hold;
    p_row = row_s;
    p_col = col_s;
  end

  task automatic one_access(input logic m, input logic e, input logic s, input logic w,
                            input logic [2:0] bz, input logic keep);
    logic [31:0] r;
    logic [3:0]  lat;
    r = next_rand();
    lat = (bz != 3'h0) ? 4'h3 : (m ? 4'h1 : 4'h2);
    @(posedge clk_i);
    #1;
    {prog, mode, ecol, style, wdly, pipe, latch_cfg} = {1'h1, m, e, s, w, r[27], r[28]};
    @(posedge clk_i);
    #1;
    prog = 1'h0;
    exp_q.push_back({2'h1, lat, 4'h1 << r[5:4], r[14:6], 2'h0, 11'h0});
    exp_q.push_back({2'h2, (r[26] & w) ? 4'h3 : 4'h2, r[3:0] | 4'h1, r[23:15], ~r[26] & ~e, 1'h1, 11'h0});
    // Pipelining returns the address lines to the live row once the column has been held a full cycle.
    exp_q.push_back({2'h3, 4'h1, e ? 4'h0 : (r[3:0] | 4'h1),
                     (r[27] && !(r[26] && w && r[25:24] == 2'h0)) ? ~r[14:6] : r[23:15], ~r[26] & ~e, ~s, 11'h0});
    busy = bz;
    fork
      begin
        repeat (3) @(posedge clk_i);
        #1;
        busy = 3'h0;
      end
    join_none
    vpa_host_model_inst.access(r[26], r[3:0] | 4'h1, r[5:4], r[14:6], r[23:15], int'(r[25:24]) + 2, keep);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    for (int i = 0; i < 19; i++) begin
      one_access(i < 16 ? i[0] : 1'h1, i[1], i[2], i[3], i < 16 ? 3'h0 : 3'(1 << (i - 16)), i == 15);
      $display("test %0d done", i);
    end
    check_note(32'h0);
    report_and_stop();
  end

  initial begin
    #(5000 * 100);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
